// ===== src/lsb_unit_pkg.sv
// Summary of operation
// RULE1: pointer ends at next instruction's first word
// RULE2: pointer references use the first word address
// RULE3: opcode high byte, coded fields low byte
// RULE4: equal register fields act on one register
// RULE5: index select zero means no indexing
// RULE6: short displaced address is R1 plus offset
// RULE7: short indexed address is chosen register's contents
// RULE8: deref flag makes computed address indirect
// RULE9: load_direct reads operand into target register
// RULE10: load_immediate copies second word, skips it
// RULE11: load_short_displaced reads R1 plus offset
// RULE12: load_short_indexed reads word at register address
// RULE13: store_direct writes target register to operand
// RULE14: store_immediate writes word after first word
// RULE15: store_short_displaced writes R1 plus offset
// RULE16: store_short_indexed writes at register address
// RULE17: byte load fills low byte, zeroes high
// RULE18: even register base, odd register signed displacement
// RULE19: word address is base plus displacement shifted
// RULE20: displacement low bit picks memory half
// RULE21: only destination or addressed word changes
package lsb_unit_pkg;

   // ======================================================
   // register map
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PTR = 8'h08;
   localparam logic [7:0] OFS_INSN = 8'h0C;
   localparam logic [1:0] OFS_GREG_PAGE = 2'h1;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_STEP_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_UNDEF_BIT = 1;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [15:0] GREG_RESET = 16'h0000;

   // ======================================================
   // instruction fields
   localparam int OPC_LSB = 8;
   localparam int TGT_LSB = 4;
   localparam int DEREF_BIT = 3;
   localparam int HALF_PICK_BIT = 0;
   localparam logic [3:0] SHORT_BASE_REG = 4'h1;
   localparam logic [15:0] LEN_ONE = 16'h0001;
   localparam logic [15:0] LEN_TWO = 16'h0002;

   // ======================================================
   // operation codes
   localparam logic [7:0] OPC_LOAD_DIRECT = 8'hE5;
   localparam logic [7:0] OPC_STORE_DIRECT = 8'hE6;
   localparam logic [7:0] OPC_LOAD_IMMEDIATE = 8'hC5;
   localparam logic [7:0] OPC_STORE_IMMEDIATE = 8'hC6;
   localparam logic [7:0] OPC_LOAD_SHORT_DISPLACED = 8'h25;
   localparam logic [7:0] OPC_STORE_SHORT_DISPLACED = 8'h26;
   localparam logic [7:0] OPC_LOAD_SHORT_INDEXED = 8'h35;
   localparam logic [7:0] OPC_STORE_SHORT_INDEXED = 8'h36;
   localparam logic [7:0] OPC_LOAD_BYTE_PAIRED = 8'h39;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_FETCH = 6'h02,
      ST_DECODE = 6'h04,
      ST_WORD2 = 6'h08,
      ST_IND = 6'h10,
      ST_OPER = 6'h20
   } exec_state_t;

endpackage

// ===== src/load_store_byte_unit.sv
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module load_store_byte_unit (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RESET_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // core memory port
   output logic MEM_REQ_O,
   output logic MEM_WE_O,
   output logic [15:0] MEM_ADDR_O,
   output logic [15:0] MEM_WDATA_O,
   input wire logic [15:0] MEM_RDATA_I,
   input wire logic MEM_ACK_I
);
   import lsb_unit_pkg::*;

   // ======================================================
   // state
   exec_state_t state_q;
   logic [15:0] regs_q [16];
   logic [15:0] pc_q;
   logic [15:0] ir_q;
   logic [15:0] addr_q;
   logic [15:0] wdata_q;
   logic we_q;
   logic half_q;
   logic run_q;
   logic step_q;
   logic undef_q;
   logic [31:0] prdata_q;
   logic perr_q;

   // ======================================================
   // instruction decode
   logic [7:0] opc;
   logic [3:0] tgt;
   logic deref;
   logic [2:0] idx_sel;
   logic [3:0] ptr_sel;
   logic [15:0] idx_val;
   logic [15:0] pair_base;
   logic [15:0] pair_disp;
   logic [15:0] byte_addr;
   logic two_word;
   logic is_store;
   logic known_op;
   logic [15:0] ins_len;

   assign opc = ir_q[15:OPC_LSB]; // RULE3
   assign tgt = ir_q[OPC_LSB-1:TGT_LSB]; // RULE3
   assign deref = ir_q[DEREF_BIT];
   assign idx_sel = ir_q[DEREF_BIT-1:0];
   assign ptr_sel = ir_q[TGT_LSB-1:0];
   // zero select leaves the address alone
   assign idx_val = (idx_sel == 3'h0) ? 16'h0000
                    : regs_q[{1'b0, idx_sel}]; // RULE5
   // odd select values fold onto the even/odd pair
   assign pair_base = regs_q[{ptr_sel[3:1], 1'b0}]; // RULE18
   assign pair_disp = regs_q[{ptr_sel[3:1], 1'b1}]; // RULE18
   assign byte_addr = pair_base
                      + {pair_disp[15], pair_disp[15:1]}; // RULE19

   always_comb begin
      two_word = 1'b0;
      is_store = 1'b0;
      known_op = 1'b1;
      case (opc)
         OPC_LOAD_DIRECT, OPC_LOAD_IMMEDIATE: begin
            two_word = 1'b1;
         end
         OPC_STORE_DIRECT, OPC_STORE_IMMEDIATE: begin
            two_word = 1'b1;
            is_store = 1'b1;
         end
         OPC_STORE_SHORT_DISPLACED, OPC_STORE_SHORT_INDEXED: begin
            is_store = 1'b1;
         end
         OPC_LOAD_SHORT_DISPLACED, OPC_LOAD_SHORT_INDEXED,
         OPC_LOAD_BYTE_PAIRED: begin
            known_op = 1'b1;
         end
         default: begin
            known_op = 1'b0;
         end
      endcase
   end

   assign ins_len = two_word ? LEN_TWO : LEN_ONE; // RULE1

   // ======================================================
   // completion and register file write
   logic busy;
   logic leave_idle;
   logic fin;
   logic rf_we;
   logic [15:0] rf_wd;
   logic [7:0] picked_byte;

   assign busy = (state_q != ST_IDLE);
   assign leave_idle = (state_q == ST_IDLE) && (run_q || step_q);
   assign fin = ((state_q == ST_DECODE) && !known_op)
                || ((state_q == ST_WORD2) && MEM_ACK_I
                    && (opc == OPC_LOAD_IMMEDIATE))
                || ((state_q == ST_OPER) && MEM_ACK_I);
   assign picked_byte = half_q ? MEM_RDATA_I[7:0]
                        : MEM_RDATA_I[15:8]; // RULE20
   assign rf_we = ((state_q == ST_WORD2) && MEM_ACK_I
                   && (opc == OPC_LOAD_IMMEDIATE)) // RULE10
                  || ((state_q == ST_OPER) && MEM_ACK_I
                      && !is_store); // RULE21

   always_comb begin
      if (state_q == ST_WORD2) begin
         rf_wd = MEM_RDATA_I; // RULE10
      end else if (opc == OPC_LOAD_BYTE_PAIRED) begin
         rf_wd = {8'h00, picked_byte}; // RULE17
      end else begin
         rf_wd = MEM_RDATA_I; // RULE9
      end
   end

   // ======================================================
   // apb slave
   logic apb_setup;
   logic apb_access;
   logic apb_wr;
   logic sw_ok;
   logic greg_hit;
   logic [3:0] greg_idx;
   logic addr_hit;
   logic [31:0] rd_mux;

   assign apb_setup = PSEL_I && !PENABLE_I;
   assign apb_access = PSEL_I && PENABLE_I;
   assign apb_wr = apb_access && PWRITE_I && !perr_q;
   // APB writes to pointer and registers only land while nothing runs
   assign sw_ok = !busy && !run_q && !step_q;
   assign greg_hit = (PADDR_I[7:6] == OFS_GREG_PAGE)
                     && (PADDR_I[1:0] == 2'h0);
   assign greg_idx = PADDR_I[5:2];
   assign addr_hit = greg_hit || (PADDR_I == OFS_CTRL)
                     || (PADDR_I == OFS_STATUS)
                     || (PADDR_I == OFS_PTR)
                     || (PADDR_I == OFS_INSN);

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (greg_hit) begin
         rd_mux = {16'h0000, regs_q[greg_idx]};
      end else begin
         case (PADDR_I)
            OFS_CTRL: begin
               rd_mux[CTRL_RUN_BIT] = run_q;
            end
            OFS_STATUS: begin
               rd_mux[STAT_BUSY_BIT] = busy;
               rd_mux[STAT_UNDEF_BIT] = undef_q;
            end
            OFS_PTR: begin
               rd_mux = {16'h0000, pc_q};
            end
            OFS_INSN: begin
               rd_mux = {16'h0000, ir_q};
            end
            default: begin
               rd_mux = 32'h0000_0000;
            end
         endcase
      end
   end

   // read data sampled in setup so it leaves a flip-flop
   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         prdata_q <= 32'h0000_0000;
         perr_q <= 1'b0;
      end else if (apb_setup) begin
         prdata_q <= rd_mux;
         perr_q <= !addr_hit;
      end
   end

   assign PRDATA_O = prdata_q;
   assign PREADY_O = apb_access;
   assign PSLVERR_O = apb_access && perr_q;

   // ======================================================
   // control and status
   logic ctrl_wr;
   logic undef_clr;

   assign ctrl_wr = apb_wr && (PADDR_I == OFS_CTRL);
   assign undef_clr = apb_wr && (PADDR_I == OFS_STATUS)
                      && PWDATA_I[STAT_UNDEF_BIT];

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         run_q <= 1'b0;
         step_q <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            run_q <= PWDATA_I[CTRL_RUN_BIT];
         end
         // a new step request beats the consume
         step_q <= (step_q && !leave_idle)
                   || (ctrl_wr && PWDATA_I[CTRL_STEP_BIT]);
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         undef_q <= 1'b0;
      end else begin
         undef_q <= (undef_q && !undef_clr)
                    || ((state_q == ST_DECODE) && !known_op);
      end
   end

   // ======================================================
   // next fetch pointer
   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         pc_q <= PTR_RESET;
      end else if (fin) begin
         pc_q <= pc_q + ins_len; // RULE1
      end else if (apb_wr && sw_ok && (PADDR_I == OFS_PTR)) begin
         pc_q <= PWDATA_I[15:0];
      end
   end

   // ======================================================
   // general register file
   for (genvar g = 0; g < 16; g++) begin : g_greg
      always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
         if (RESET_I) begin
            regs_q[g] <= GREG_RESET;
         end else if (rf_we && (tgt == 4'(g))) begin
            regs_q[g] <= rf_wd; // RULE4
         end else if (apb_wr && sw_ok && greg_hit
                      && (greg_idx == 4'(g))) begin
            regs_q[g] <= PWDATA_I[15:0];
         end
      end
   end

   // ======================================================
   // execution sequencer
   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         state_q <= ST_IDLE;
         ir_q <= 16'h0000;
         addr_q <= 16'h0000;
         we_q <= 1'b0;
         half_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               we_q <= 1'b0;
               if (run_q || step_q) begin
                  addr_q <= pc_q;
                  state_q <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (MEM_ACK_I) begin
                  ir_q <= MEM_RDATA_I;
                  state_q <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               we_q <= is_store;
               case (opc)
                  OPC_LOAD_DIRECT, OPC_STORE_DIRECT,
                  OPC_LOAD_IMMEDIATE, OPC_STORE_IMMEDIATE: begin
                     we_q <= 1'b0;
                     addr_q <= pc_q + LEN_ONE; // RULE2
                     state_q <= ST_WORD2;
                  end
                  OPC_LOAD_SHORT_DISPLACED,
                  OPC_STORE_SHORT_DISPLACED: begin // RULE11 RULE15
                     addr_q <= regs_q[SHORT_BASE_REG]
                               + {12'h000, ptr_sel}; // RULE6
                     state_q <= ST_OPER;
                  end
                  OPC_LOAD_SHORT_INDEXED,
                  OPC_STORE_SHORT_INDEXED: begin // RULE12 RULE16
                     addr_q <= regs_q[ptr_sel]; // RULE7
                     state_q <= ST_OPER;
                  end
                  OPC_LOAD_BYTE_PAIRED: begin
                     addr_q <= byte_addr; // RULE19
                     half_q <= pair_disp[HALF_PICK_BIT]; // RULE20
                     state_q <= ST_OPER;
                  end
                  default: begin
                     // unknown codes retire as one-word no-ops
                     we_q <= 1'b0;
                     state_q <= ST_IDLE;
                  end
               endcase
            end
            ST_WORD2: begin
               if (MEM_ACK_I) begin
                  if (opc == OPC_LOAD_IMMEDIATE) begin
                     state_q <= ST_IDLE; // RULE10
                  end else if (opc == OPC_STORE_IMMEDIATE) begin
                     we_q <= 1'b1; // RULE14
                     state_q <= ST_OPER;
                  end else begin
                     // index first, then one level of indirection
                     addr_q <= MEM_RDATA_I + idx_val; // RULE5
                     we_q <= is_store && !deref;
                     state_q <= deref ? ST_IND : ST_OPER; // RULE8
                  end
               end
            end
            ST_IND: begin
               if (MEM_ACK_I) begin
                  addr_q <= MEM_RDATA_I; // RULE8
                  we_q <= is_store;
                  state_q <= ST_OPER;
               end
            end
            ST_OPER: begin
               if (MEM_ACK_I) begin
                  we_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               we_q <= 1'b0;
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // store data is captured once; registers take no APB writes while busy
   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         wdata_q <= 16'h0000;
      end else if (state_q == ST_DECODE) begin
         wdata_q <= regs_q[tgt]; // RULE13
      end
   end

   assign MEM_REQ_O = busy && (state_q != ST_DECODE);
   assign MEM_WE_O = we_q;
   assign MEM_ADDR_O = addr_q;
   assign MEM_WDATA_O = wdata_q;

   // ======================================================
   // checks
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RESET_I);

   AST_PTR_ADVANCE: assert property ( // RULE1
      fin |=> pc_q == $past(pc_q) + $past(ins_len))
      else $error("pointer did not advance by instruction length");

   AST_SECOND_WORD: assert property ( // RULE2
      (state_q == ST_WORD2) |-> MEM_ADDR_O == pc_q + LEN_ONE)
      else $error("second word not read after first word");

   AST_STORE_IMMEDIATE: assert property ( // RULE14
      (state_q == ST_OPER && opc == OPC_STORE_IMMEDIATE)
      |-> MEM_WE_O && MEM_ADDR_O == pc_q + LEN_ONE)
      else $error("store immediate went to wrong word");

   AST_SHORT_DISPLACED: assert property ( // RULE6
      (state_q == ST_OPER && (opc == OPC_LOAD_SHORT_DISPLACED
       || opc == OPC_STORE_SHORT_DISPLACED))
      |-> MEM_ADDR_O == regs_q[SHORT_BASE_REG] + {12'h000, ptr_sel})
      else $error("short displaced address wrong");

   AST_SHORT_INDEXED: assert property ( // RULE7
      (state_q == ST_OPER && (opc == OPC_LOAD_SHORT_INDEXED
       || opc == OPC_STORE_SHORT_INDEXED))
      |-> MEM_ADDR_O == regs_q[ptr_sel])
      else $error("short indexed address wrong");

   AST_LOAD_WORD: assert property ( // RULE9
      (state_q == ST_OPER && MEM_ACK_I && !is_store
       && opc != OPC_LOAD_BYTE_PAIRED)
      |=> regs_q[$past(tgt)] == $past(MEM_RDATA_I))
      else $error("loaded word missing from target register");

   AST_BYTE_LOAD: assert property ( // RULE17
      (state_q == ST_OPER && MEM_ACK_I && opc == OPC_LOAD_BYTE_PAIRED)
      |=> regs_q[$past(tgt)] == {8'h00, $past(half_q)
          ? $past(MEM_RDATA_I[7:0]) : $past(MEM_RDATA_I[15:8])})
      else $error("byte load result wrong");

   AST_BYTE_ADDR: assert property ( // RULE19
      (state_q == ST_OPER && opc == OPC_LOAD_BYTE_PAIRED)
      |-> MEM_ADDR_O == byte_addr && !MEM_WE_O)
      else $error("byte word address wrong");

   AST_WRITE_ONLY_OPERAND: assert property ( // RULE21
      (MEM_REQ_O && MEM_WE_O)
      |-> state_q == ST_OPER && MEM_WDATA_O == regs_q[tgt])
      else $error("memory written outside operand access");

   AST_NO_INDEX: assert property ( // RULE5
      (state_q == ST_WORD2 && MEM_ACK_I && idx_sel == 3'h0
       && opc == OPC_LOAD_DIRECT)
      |=> MEM_ADDR_O == $past(MEM_RDATA_I))
      else $error("zero index select altered the address");

   AST_INDIRECT: assert property ( // RULE8
      (state_q == ST_IND && MEM_ACK_I)
      |=> state_q == ST_OPER && MEM_ADDR_O == $past(MEM_RDATA_I))
      else $error("indirect word not used as operand address");

endmodule

// ===== verif/core_mem_model.sv
`timescale 1ns/100ps
// ======================================================
// core memory behind the unit's memory port
module core_mem_model (
   // clock
   input wire logic clk_i,
   // memory port
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o,
   output logic ack_o,
   // answer delay for the next access
   input wire logic [1:0] lat_i
);
   logic [15:0] cells [0:65535];
   logic [1:0] wait_q = 2'h0;

   initial begin
      for (int i = 0; i < 65536; i++) begin
         cells[i] = 16'(i) ^ 16'hA5C3;
      end
      rdata_o = 16'h0000;
      ack_o = 1'b0;
   end

   // read data is only good with ack; it toggles otherwise so a
   // sample taken at the wrong edge cannot match by luck
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
         if (wait_q == 2'h0) begin
            ack_o <= 1'b1;
            wait_q <= lat_i;
            if (we_i) begin
               cells[addr_i] <= wdata_i;
            end else begin
               rdata_o <= cells[addr_i];
            end
         end else begin
            wait_q <= wait_q - 2'h1;
         end
      end
   end
endmodule

// ===== verif/load_store_byte_unit_tb_top.sv
`timescale 1ns/100ps
module load_store_byte_unit_tb_top;
   import lsb_unit_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic mem_req;
   logic mem_we;
   logic mem_ack;
   logic [15:0] mem_addr;
   logic [15:0] mem_wdata;
   logic [15:0] mem_rdata;
   logic [1:0] lat = 2'h0;
   integer seed = 32'hd7ca2e64;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   logic [64:0] exp_q [$];
   logic [31:0] wr_q [$];
   logic [64:0] e;
   logic [15:0] r [0:15];
   logic [15:0] pc = 16'h0100;
   logic [31:0] rd;

   always #2.5 clk = ~clk;

   load_store_byte_unit load_store_byte_unit_inst (
      .SYS_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .MEM_REQ_O(mem_req), .MEM_WE_O(mem_we),
      .MEM_ADDR_O(mem_addr), .MEM_WDATA_O(mem_wdata),
      .MEM_RDATA_I(mem_rdata), .MEM_ACK_I(mem_ack));

   core_mem_model core_mem_model_inst (
      .clk_i(clk), .req_i(mem_req), .we_i(mem_we), .addr_i(mem_addr),
      .wdata_i(mem_wdata), .rdata_o(mem_rdata), .ack_o(mem_ack),
      .lat_i(lat));

   // ======================================================
   // closing and reporting
   task automatic stop_test;
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic fail(input string s);
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, s);
   endtask

   function automatic logic [15:0] mw(input logic [15:0] a);
      return core_mem_model_inst.cells[a];
   endfunction

   // ======================================================
   // apb master; a read with zero mask is a poll, not a check
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] m,
                      input logic err);
      if (!w) exp_q.push_back({err, m, d});
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ======================================================
   // one instruction by single step
   task automatic run(input logic [15:0] w0, w1, len);
      core_mem_model_inst.cells[pc] = w0;
      core_mem_model_inst.cells[pc + 16'h1] = w1;
      lat <= 2'($random(seed));
      apb(1'b1, OFS_PTR, {16'h0, pc}, 32'h0, 1'b0);
      apb(1'b1, OFS_CTRL, 32'h2, 32'h0, 1'b0);
      rd = 32'h1;
      while (rd[STAT_BUSY_BIT] !== 1'b0) begin
         apb(1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0);
      end
      apb(1'b0, OFS_PTR, {16'h0, pc + len}, '1, 1'b0);
      apb(1'b0, OFS_INSN, {16'h0, w0}, '1, 1'b0);
      pc = pc + 16'h10;
   endtask

   task automatic ld(input logic [15:0] w0, w1, len, v);
      run(w0, w1, len);
      r[w0[7:4]] = v;
      apb(1'b0, {2'b01, w0[7:4], 2'b00}, {16'h0, v}, '1, 1'b0);
   endtask

   task automatic st(input logic [15:0] w0, w1, len, loc);
      wr_q.push_back({loc, r[w0[7:4]]});
      run(w0, w1, len);
   endtask

   // ======================================================
   // result monitor
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         e = exp_q.pop_front();
         if (e[63:32] !== 32'h0) begin
            checked++;
            if ((prdata & e[63:32]) !== (e[31:0] & e[63:32])
                || pslverr !== e[64]) fail("apb read data or error");
         end
      end
      if (mem_req === 1'b1 && mem_we === 1'b1 && mem_ack === 1'b1) begin
         checked++;
         if (wr_q.size() == 0) begin
            fail("unexpected memory write");
         end else if ({mem_addr, mem_wdata} !== wr_q.pop_front()) begin
            fail("store address or data");
         end
      end
      cyc++;
      if (cyc == 40000) begin
         fail("timeout");
         stop_test();
      end
   end

   // ======================================================
   // main sequence
   initial begin
      logic [15:0] b;
      logic [15:0] d;
      logic [15:0] w;
      for (int n = 0; n < 16; n++) r[n] = 16'($random(seed));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, OFS_PTR, 32'h0, '1, 1'b0);
      apb(1'b0, 8'h48, 32'h0, '1, 1'b0);
      apb(1'b1, 8'h10, 32'h1234, 32'h0, 1'b0);
      apb(1'b0, 8'h10, 32'h0, '1, 1'b1);
      for (int n = 0; n < 16; n++) begin
         apb(1'b1, {2'b01, 4'(n), 2'b00}, {16'h0, r[n]}, 32'h0, 1'b0);
      end
      ld({OPC_LOAD_DIRECT, 8'h20}, 16'h2000, 16'h2, mw(16'h2000));
      ld({OPC_LOAD_DIRECT, 8'h63}, 16'h2010, 16'h2,
         mw(16'h2010 + r[3]));
      ld({OPC_LOAD_DIRECT, 8'h7B}, 16'h2020, 16'h2,
         mw(mw(16'h2020 + r[3])));
      st({OPC_STORE_DIRECT, 8'h60}, 16'h2100, 16'h2, 16'h2100);
      st({OPC_STORE_DIRECT, 8'h2A}, 16'h2100, 16'h2,
         mw(16'h2100 + r[2]));
      ld({OPC_LOAD_IMMEDIATE, 8'h90}, 16'hBEEF, 16'h2, 16'hBEEF);
      st({OPC_STORE_IMMEDIATE, 8'h90}, 16'h0, 16'h2,
         pc + 16'h1);
      ld({OPC_LOAD_SHORT_DISPLACED, 8'h1F}, 16'h0, 16'h1,
         mw(r[1] + 16'hF));
      st({OPC_STORE_SHORT_DISPLACED, 8'h50}, 16'h0, 16'h1, r[1]);
      ld({OPC_LOAD_SHORT_INDEXED, 8'h00}, 16'h0, 16'h1,
         mw(r[0]));
      st({OPC_STORE_SHORT_INDEXED, 8'hCF}, 16'h0, 16'h1, r[15]);
      // negative odd displacement, then positive even one
      for (int k = 0; k < 2; k++) begin
         b = 16'($random(seed));
         d = (k == 0) ? 16'hFFFD : 16'h0004;
         r[4] = b;
         r[5] = d;
         apb(1'b1, 8'h50, {16'h0, b}, 32'h0, 1'b0);
         apb(1'b1, 8'h54, {16'h0, d}, 32'h0, 1'b0);
         w = mw(b + {d[15], d[15:1]});
         w = d[0] ? {8'h0, w[7:0]} : {8'h0, w[15:8]};
         ld({OPC_LOAD_BYTE_PAIRED, 4'h8, 4'(4 + k)}, 16'h0, 16'h1,
            w);
      end
      // undefined code retires as a one-word no-op and is flagged
      run({8'h66, 8'h00}, 16'h0, 16'h1);
      apb(1'b0, OFS_STATUS, 32'h2, 32'h2, 1'b0);
      apb(1'b1, OFS_STATUS, 32'h2, 32'h0, 1'b0);
      apb(1'b0, OFS_STATUS, 32'h0, 32'h3, 1'b0);
      // step reads back as zero, run was never set
      apb(1'b0, OFS_CTRL, 32'h0, 32'h3, 1'b0);
      for (int n = 0; n < 16; n++) begin
         apb(1'b0, {2'b01, 4'(n), 2'b00}, {16'h0, r[n]}, '1, 1'b0);
      end
      checked++;
      if (wr_q.size() != 0) fail("store missing");
      stop_test();
   end
endmodule
